/* sim/ssm_chk.sv */
// port assertions for the status and serial monitor block
`timescale 1ns/1ns
module ssm_chk
   import ssm_pkg::*;
#(
   parameter int unsigned BAUD_RATE = DEFAULT_BAUD
) (
   input wire logic       i_clock,
   input wire logic       i_nrst,
   input wire ssm_state_t i_ctrl_state,
   input wire ssm_flags_t i_ctrl_flags,
   input wire logic       i_ctrl_heartbeat,
   input wire logic       o_status_valid,
   input wire ssm_state_t o_status_state,
   input wire ssm_flags_t o_status_flags,
   input wire logic       o_status_heartbeat,
   input wire logic       i_tx_valid,
   input wire logic       o_tx_ready,
   input wire logic       o_rx_valid,
   input wire logic [7:0] o_rx_data,
   input wire logic       o_rx_frame_err,
   input wire logic       o_monitor_tx,
   input wire logic       o_flash_clk
);
   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   chk_flash_div: assert property ($past(i_nrst) |-> o_flash_clk != $past(o_flash_clk))
      else $error("flash clock missed a toggle");
   chk_valid_up: assert property ($past(i_nrst) |-> o_status_valid)
      else $error("status valid low after reset");
   chk_state_copy: assert property ($past(i_nrst) |-> o_status_state == $past(i_ctrl_state))
      else $error("state output not one cycle behind");
   chk_beat_copy: assert property ($past(i_nrst) |-> o_status_heartbeat == $past(i_ctrl_heartbeat))
      else $error("heartbeat output not one cycle behind");
   chk_unc_owner: assert property ($past(i_nrst) |-> o_status_flags.uncorrectable ==
      ($past(i_ctrl_state.correction) ? $past(i_ctrl_flags.uncorrectable) : $past(o_status_flags.uncorrectable)))
      else $error("uncorrectable flag moved outside its state");
   chk_ess_owner: assert property ($past(i_nrst) |-> o_status_flags.essential ==
      ($past(i_ctrl_state.classification) ? $past(i_ctrl_flags.essential) : $past(o_status_flags.essential)))
      else $error("essential flag moved outside its state");
   chk_tx_start: assert property (i_tx_valid && o_tx_ready |=> (!o_monitor_tx && !o_tx_ready) [*8])
      else $error("accepted byte gave no start bit");
   chk_tx_idle: assert property (o_tx_ready |-> o_monitor_tx)
      else $error("line not idle high while ready");
   chk_rx_pulse: assert property (o_rx_valid |=> !o_rx_valid && $stable(o_rx_data))
      else $error("receive pulse longer than one cycle");
   chk_rx_bad: assert property (o_rx_frame_err |-> !o_rx_valid && $stable(o_rx_data))
      else $error("framing error updated data");
endmodule : ssm_chk

bind ssm_top ssm_chk #(.BAUD_RATE(BAUD_RATE)) u_chk (.i_clock, .i_nrst, .i_ctrl_state, .i_ctrl_flags,
   .i_ctrl_heartbeat, .o_status_valid, .o_status_state, .o_status_flags, .o_status_heartbeat, .i_tx_valid,
   .o_tx_ready, .o_rx_valid, .o_rx_data, .o_rx_frame_err, .o_monitor_tx, .o_flash_clk);

/* sim/ssm_term.sv */
// serial terminal and status observer facing the monitor port
`timescale 1ns/1ns
module ssm_term #(
   parameter int unsigned BIT_NS = 52083
) (
   input  wire logic  i_line,
   input  wire logic  i_obs,
   input  wire logic  i_beat,
   output logic       o_line,
   output logic [7:0] o_byte,
   output int         o_count,
   output int         o_hi_ns,
   output logic       o_armed
);
   // ************************************************************
   // terminal
   // ************************************************************
   initial begin
      o_line = 1'b1;
      o_byte = 8'h00;
      o_count = 0;
      o_hi_ns = 0;
      o_armed = 1'b0;
   end
   // 8-N-1 sampled mid-bit at nominal rate
   always @(negedge i_line) begin : rx
      logic [7:0] b;
      #(BIT_NS / 2);
      for (int i = 0; i < 8; i++) begin
         #(BIT_NS);
         b[i] = i_line;
      end
      #(BIT_NS);
      o_byte = b;
      o_count = o_count + 1;
   end
   // width of each high run, for bit-time checks
   always @(posedge i_line) begin : run
      time t;
      t = $time;
      @(negedge i_line);
      o_hi_ns = int'($time - t);
   end
   // armed by first beat edge seen in observation
   always @(posedge i_beat) if (i_obs) o_armed = 1'b1;
   // nominal-rate frame, stop level chosen by caller
   task automatic send(input logic [7:0] b, input logic stop);
      o_line = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < 8; i++) begin
         o_line = b[i];
         #(BIT_NS);
      end
      o_line = stop;
      #(BIT_NS);
      o_line = 1'b1;
      #(BIT_NS);
   endtask : send
endmodule : ssm_term

/* sim/ssm_top_bench.sv */
// self-checking bench for the status and serial monitor block
`timescale 1ns/1ns
module ssm_top_bench;
   import ssm_pkg::*;
   localparam int unsigned BAUD = 19200;
   localparam int unsigned TC   = (20000000 + 8 * BAUD) / (16 * BAUD) - 1;
   localparam int unsigned BITC = 16 * (TC + 1);
   logic       i_clock, i_nrst, i_ctrl_heartbeat, i_tx_valid, i_monitor_rx;
   ssm_state_t i_ctrl_state, o_status_state;
   ssm_flags_t i_ctrl_flags, o_status_flags;
   logic [7:0] i_tx_data, o_rx_data, t_byte;
   logic       o_status_valid, o_status_heartbeat, o_tx_ready, o_rx_valid;
   logic       o_rx_frame_err, o_monitor_tx, o_flash_clk, t_armed;
   int         num_errors = 0;
   int         n_checks = 0;
   int         t_count, t_hi;

   ssm_top #(.BAUD_RATE(BAUD)) DUT (.i_clock, .i_nrst, .i_ctrl_state, .i_ctrl_flags, .i_ctrl_heartbeat,
      .o_status_valid, .o_status_state, .o_status_flags, .o_status_heartbeat, .i_tx_valid, .i_tx_data,
      .o_tx_ready, .o_rx_valid, .o_rx_data, .o_rx_frame_err, .o_monitor_tx, .i_monitor_rx, .o_flash_clk);
   ssm_term #(.BIT_NS(1000000000 / BAUD)) term (.i_line(o_monitor_tx), .i_obs(o_status_state.observation),
      .i_beat(o_status_heartbeat), .o_line(i_monitor_rx), .o_byte(t_byte), .o_count(t_count),
      .o_hi_ns(t_hi), .o_armed(t_armed));

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic put(input ssm_state_t s, input ssm_flags_t f, input logic h);
      @(negedge i_clock);
      i_ctrl_state = s;
      i_ctrl_flags = f;
      i_ctrl_heartbeat = h;
      @(negedge i_clock);
   endtask : put
   // source holds the byte until ready was seen
   task automatic tx_byte(input logic [7:0] b);
      int n;
      n = 0;
      @(negedge i_clock);
      i_tx_valid = 1'b1;
      i_tx_data = b;
      while (o_tx_ready !== 1'b1 && n < 40000) begin
         @(negedge i_clock);
         n++;
      end
      chk(16'(o_tx_ready), 16'h0001);
      @(negedge i_clock);
      i_tx_valid = 1'b0;
   endtask : tx_byte
   task automatic wait_term(input int n);
      int k;
      k = 0;
      while (t_count < n && k < 30000) begin
         @(negedge i_clock);
         k++;
      end
      chk(16'(t_count >= n), 16'h0001);
   endtask : wait_term
   task automatic wait_rx(input logic [7:0] d, input logic e);
      int n;
      n = 0;
      while (o_rx_valid !== 1'b1 && o_rx_frame_err !== 1'b1 && n < 15000) begin
         @(negedge i_clock);
         n++;
      end
      chk({14'h0, o_rx_frame_err, o_rx_valid}, {14'h0, e, !e});
      chk({8'h00, o_rx_data}, {8'h00, d});
   endtask : wait_rx
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // ************************************************************
   // stimulus
   // ************************************************************
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end
   initial begin
      repeat (90000) @(posedge i_clock);
      num_errors++;
      conclude();
   end
   initial begin
      {i_nrst, i_ctrl_heartbeat, i_tx_valid, i_ctrl_state, i_ctrl_flags, i_tx_data} = '0;
      repeat (20) @(negedge i_clock);
      i_nrst = 1'b1;
      // flags offered outside their states are dropped
      put(5'h08, 2'h3, 1'b0);
      chk(16'(o_status_state), 16'h0008);
      chk(16'(o_status_flags), 16'h0000);
      put(5'h08, 2'h0, 1'b1);
      chk(16'(o_status_heartbeat), 16'h0001);
      chk(16'(t_armed), 16'h0001);
      put(5'h08, 2'h0, 1'b0);
      // report goes ahead of the held user byte
      fork
         tx_byte(8'ha5);
         begin
            wait_term(1);
            chk({8'h00, t_byte}, 16'h00c4);
         end
      join
      wait_term(2);
      chk({8'h00, t_byte}, 16'h00a5);
      chk(16'(t_hi / 50), 16'(BITC));
      put(5'h04, 2'h3, 1'b0);
      chk(16'(o_status_flags), 16'h0002);
      put(5'h02, 2'h1, 1'b0);
      chk(16'(o_status_flags), 16'h0003);
      put(5'h08, 2'h0, 1'b0);
      chk(16'(o_status_flags), 16'h0003);
      wait_term(3);
      repeat (12 * BITC) @(negedge i_clock);
      chk({8'h00, t_byte}, 16'h00c7);
      chk(16'(t_count), 16'h0003);
      fork
         term.send(8'h0d, 1'b1);
         wait_rx(8'h0d, 1'b0);
      join
      fork
         term.send(8'h55, 1'b0);
         wait_rx(8'h0d, 1'b1);
      join
      conclude();
   end
endmodule : ssm_top_bench

/* verilog/ssm_pkg.sv */
// shared constants and types of the status and serial monitor block
package ssm_pkg;

   // ************************************************************
   // clocking and bit timing
   // ************************************************************
   localparam int unsigned CLOCK_HZ      = 20000000;
   localparam int unsigned CLOCK_NS      = 50;
   localparam int unsigned DEFAULT_BAUD  = 9600;
   localparam int unsigned TICKS_PER_BIT = 16;
   localparam int unsigned TC_W          = 16;
   localparam int unsigned PHASE_W       = 4;
   localparam int unsigned DATA_BITS     = 8;
   localparam int unsigned BIT_IDX_W     = 3;

   // round to nearest, then minus one
   function automatic logic [TC_W-1:0] ssm_terminal_count(input int unsigned baud);
      int unsigned q;
      q = (CLOCK_HZ + (TICKS_PER_BIT * baud) / 2) / (TICKS_PER_BIT * baud);
      return TC_W'(q - 1);
   endfunction : ssm_terminal_count

   localparam logic [PHASE_W-1:0]   SAMPLE_PHASE = 4'h7;
   localparam logic [PHASE_W-1:0]   LAST_PHASE   = 4'hf;
   localparam logic [BIT_IDX_W-1:0] LAST_BIT     = 3'h7;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [TC_W-1:0]      TICK_CNT_RST = 16'h0000;
   localparam logic [PHASE_W-1:0]   PHASE_RST    = 4'h0;
   localparam logic [BIT_IDX_W-1:0] BIT_IDX_RST  = 3'h0;
   localparam logic [7:0]           BYTE_RST     = 8'h00;
   localparam logic                 LINE_IDLE    = 1'b1;

   // ************************************************************
   // status report byte: tag in bit 7 only
   // ************************************************************
   localparam logic [1:0] REPORT_TAG     = 2'h2;
   localparam int unsigned REPORT_TAG_POS = 7;

   // ************************************************************
   // types
   // ************************************************************
   typedef struct packed {
      logic initialization;
      logic observation;
      logic correction;
      logic classification;
      logic injection;
   } ssm_state_t;

   typedef struct packed {
      logic uncorrectable;
      logic essential;
   } ssm_flags_t;

   typedef enum logic [1:0] {
      SSM_IDLE,
      SSM_START,
      SSM_DATA,
      SSM_STOP
   } ssm_serial_t;

endpackage : ssm_pkg

/* verilog/ssm_top.sv */
// status output group, serial monitor port and flash clock divider
// Operation
// - flash bus clock is the input clock divided by two.
// - serial bit timing comes from an enable pulse at sixteen times bit rate.
// - enable counter counts zero to terminal count inclusive, then wraps to zero.
// - terminal count parameter is clock over sixteen times baud, rounded, minus one.
// - default link is 9600 baud, 8 data bits, no parity, one stop, no flow control.
// - monitor port is exactly one transmit and one receive line, full duplex.
// - each end keeps its bit rate within one percent of nominal.
// - every status output comes from flip-flops on the input clock.
// - five state outputs together show the controller's current state.
// - error flags update only inside their owning states.
// - heartbeat output comes straight from the readback scan process.
// - first heartbeat follows observation entry within one readback scan.
// - state and flags are also reported over the serial port.
// - the bit rate parameter holds one percent only at standard rates up to 19200 baud; 921600 runs at 1250000 baud.
`timescale 1ns/1ns
module ssm_top #(
   parameter int unsigned BAUD_RATE = ssm_pkg::DEFAULT_BAUD
) (
   // clock and reset
   input  wire logic               i_clock,
   input  wire logic               i_nrst,
   // controller status, same clock
   input  wire ssm_pkg::ssm_state_t i_ctrl_state,
   input  wire ssm_pkg::ssm_flags_t i_ctrl_flags,
   input  wire logic               i_ctrl_heartbeat,
   // status outputs
   output logic                    o_status_valid,
   output ssm_pkg::ssm_state_t     o_status_state,
   output ssm_pkg::ssm_flags_t     o_status_flags,
   output logic                    o_status_heartbeat,
   // controller bytes to send
   input  wire logic               i_tx_valid,
   input  wire logic [7:0]         i_tx_data,
   output logic                    o_tx_ready,
   // received command bytes
   output logic                    o_rx_valid,
   output logic [7:0]              o_rx_data,
   output logic                    o_rx_frame_err,
   // serial monitor pins
   output logic                    o_monitor_tx,
   input  wire logic               i_monitor_rx,
   // flash bus clock
   output logic                    o_flash_clk
);
   import ssm_pkg::*;

   localparam logic [TC_W-1:0] BIT_TICK_TERMINAL_COUNT = ssm_terminal_count(BAUD_RATE);

   // ************************************************************
   // flash clock divider and bit-rate enable counter
   // ************************************************************
   logic            flash_clk_reg, flash_clk_next;
   logic [TC_W-1:0] tick_cnt_reg, tick_cnt_next;
   logic            tick;

   assign tick = (tick_cnt_reg == BIT_TICK_TERMINAL_COUNT);

   always_comb begin
      flash_clk_next = ~flash_clk_reg;
      tick_cnt_next  = tick ? TICK_CNT_RST : tick_cnt_reg + 16'h0001;
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         flash_clk_reg <= 1'b0;
         tick_cnt_reg  <= TICK_CNT_RST;
      end else begin
         flash_clk_reg <= flash_clk_next;
         tick_cnt_reg  <= tick_cnt_next;
      end
   end

   assign o_flash_clk = flash_clk_reg;

   // ************************************************************
   // status outputs
   // ************************************************************
   ssm_state_t state_reg, state_next;
   ssm_flags_t flags_reg, flags_next;
   logic       hb_reg, hb_next, valid_reg;
   logic       report_pend_reg, report_pend_next, report_take;

   always_comb begin
      state_next = i_ctrl_state;
      hb_next    = i_ctrl_heartbeat;
      flags_next = flags_reg;
      if (i_ctrl_state.correction) begin
         flags_next.uncorrectable = i_ctrl_flags.uncorrectable;
      end
      if (i_ctrl_state.classification) begin
         flags_next.essential = i_ctrl_flags.essential;
      end
      // report on change, set wins over clear
      report_pend_next = report_pend_reg;
      if (report_take) begin
         report_pend_next = 1'b0;
      end
      // only after the first sample, so reset does not send a report
      if (valid_reg && ((state_next != state_reg) || (flags_next != flags_reg))) begin
         report_pend_next = 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg       <= '0;
         flags_reg       <= '0;
         hb_reg          <= 1'b0;
         valid_reg       <= 1'b0;
         report_pend_reg <= 1'b0;
      end else begin
         state_reg       <= state_next;
         flags_reg       <= flags_next;
         hb_reg          <= hb_next;
         valid_reg       <= 1'b1;
         report_pend_reg <= report_pend_next;
      end
   end

   assign o_status_state     = state_reg;
   assign o_status_flags     = flags_reg;
   assign o_status_heartbeat = hb_reg;
   assign o_status_valid     = valid_reg;

   // ************************************************************
   // transmitter
   // ************************************************************
   ssm_serial_t          tx_st_reg, tx_st_next;
   logic [PHASE_W-1:0]   tx_ph_reg, tx_ph_next;
   logic [BIT_IDX_W-1:0] tx_bit_reg, tx_bit_next;
   logic [7:0]           tx_sh_reg, tx_sh_next;
   logic                 tx_line_reg, tx_line_next;
   logic [7:0]           report_byte;

   // report byte: tag, initialization or observation, correction, classification, injection, observation, flags packed below
   assign report_byte = {REPORT_TAG[1], state_reg.initialization | state_reg.observation,
                         state_reg.correction, state_reg.classification, state_reg.injection,
                         state_reg.observation, flags_reg};

   // reports go first; controller bytes stall meanwhile
   assign report_take = (tx_st_reg == SSM_IDLE) && report_pend_reg;
   assign o_tx_ready  = (tx_st_reg == SSM_IDLE) && !report_pend_reg;

   always_comb begin
      tx_st_next   = tx_st_reg;
      tx_ph_next   = tx_ph_reg;
      tx_bit_next  = tx_bit_reg;
      tx_sh_next   = tx_sh_reg;
      tx_line_next = tx_line_reg;
      unique case (tx_st_reg)
         SSM_IDLE: begin
            tx_line_next = LINE_IDLE;
            if (report_take || (i_tx_valid && o_tx_ready)) begin
               tx_sh_next   = report_take ? report_byte : i_tx_data;
               tx_line_next = ~LINE_IDLE;
               tx_st_next   = SSM_START;
               tx_ph_next  = PHASE_RST;
               tx_bit_next = BIT_IDX_RST;
            end
         end
         SSM_START: begin
            tx_line_next = ~LINE_IDLE;
            if (tick) begin
               tx_ph_next = tx_ph_reg + 4'h1;
               if (tx_ph_reg == LAST_PHASE) begin
                  tx_st_next   = SSM_DATA;
                  tx_line_next = tx_sh_reg[0];
               end
            end
         end
         SSM_DATA: begin
            tx_line_next = tx_sh_reg[0];
            if (tick) begin
               tx_ph_next = tx_ph_reg + 4'h1;
               if (tx_ph_reg == LAST_PHASE) begin
                  tx_sh_next   = {1'b0, tx_sh_reg[7:1]};
                  tx_bit_next  = tx_bit_reg + 3'h1;
                  tx_line_next = tx_sh_reg[1];
                  if (tx_bit_reg == LAST_BIT) begin
                     tx_st_next   = SSM_STOP;
                     tx_line_next = LINE_IDLE;
                  end
               end
            end
         end
         SSM_STOP: begin
            tx_line_next = LINE_IDLE;
            if (tick) begin
               tx_ph_next = tx_ph_reg + 4'h1;
               if (tx_ph_reg == LAST_PHASE) begin
                  tx_st_next = SSM_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_st_reg   <= SSM_IDLE;
         tx_ph_reg   <= PHASE_RST;
         tx_bit_reg  <= BIT_IDX_RST;
         tx_sh_reg   <= BYTE_RST;
         tx_line_reg <= LINE_IDLE;
      end else begin
         tx_st_reg   <= tx_st_next;
         tx_ph_reg   <= tx_ph_next;
         tx_bit_reg  <= tx_bit_next;
         tx_sh_reg   <= tx_sh_next;
         tx_line_reg <= tx_line_next;
      end
   end

   assign o_monitor_tx = tx_line_reg;

   // ************************************************************
   // receive line synchroniser and receiver
   // ************************************************************
   logic                 rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_f_reg, rx_f_next;
   ssm_serial_t          rx_st_reg, rx_st_next;
   logic [PHASE_W-1:0]   rx_ph_reg, rx_ph_next;
   logic [BIT_IDX_W-1:0] rx_bit_reg, rx_bit_next;
   logic [7:0]           rx_sh_reg, rx_sh_next;
   logic [7:0]           rx_data_reg, rx_data_next;
   logic                 rx_valid_reg, rx_valid_next;
   logic                 rx_err_reg, rx_err_next;

   always_comb begin
      rx_st_next    = rx_st_reg;
      rx_ph_next    = rx_ph_reg;
      rx_bit_next   = rx_bit_reg;
      rx_sh_next    = rx_sh_reg;
      rx_data_next  = rx_data_reg;
      rx_valid_next = 1'b0;
      rx_err_next   = 1'b0;
      // change counts once second and third stage agree
      rx_f_next     = (rx_s2_reg == rx_s3_reg) ? rx_s3_reg : rx_f_reg;
      unique case (rx_st_reg)
         SSM_IDLE: begin
            if (tick && !rx_f_reg) begin
               rx_st_next  = SSM_START;
               rx_ph_next  = PHASE_RST;
               rx_bit_next = BIT_IDX_RST;
            end
         end
         SSM_START: begin
            if (tick) begin
               rx_ph_next = rx_ph_reg + 4'h1;
               // mid start check; glitches drop back
               if (rx_ph_reg == SAMPLE_PHASE) begin
                  rx_ph_next = PHASE_RST;
                  rx_st_next = rx_f_reg ? SSM_IDLE : SSM_DATA;
               end
            end
         end
         SSM_DATA: begin
            if (tick) begin
               rx_ph_next = rx_ph_reg + 4'h1;
               if (rx_ph_reg == LAST_PHASE) begin
                  rx_sh_next  = {rx_f_reg, rx_sh_reg[7:1]};
                  rx_bit_next = rx_bit_reg + 3'h1;
                  if (rx_bit_reg == LAST_BIT) begin
                     rx_st_next = SSM_STOP;
                  end
               end
            end
         end
         SSM_STOP: begin
            if (tick) begin
               rx_ph_next = rx_ph_reg + 4'h1;
               if (rx_ph_reg == LAST_PHASE) begin
                  rx_st_next    = SSM_IDLE;
                  rx_valid_next = rx_f_reg;
                  rx_err_next   = ~rx_f_reg;
                  if (rx_f_reg) begin
                     rx_data_next = rx_sh_reg;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rx_st_reg    <= SSM_IDLE;
         rx_ph_reg    <= PHASE_RST;
         rx_bit_reg   <= BIT_IDX_RST;
         rx_sh_reg    <= BYTE_RST;
         rx_data_reg  <= BYTE_RST;
         rx_valid_reg <= 1'b0;
         rx_err_reg   <= 1'b0;
         rx_s1_reg    <= LINE_IDLE;
         rx_s2_reg    <= LINE_IDLE;
         rx_s3_reg    <= LINE_IDLE;
         rx_f_reg     <= LINE_IDLE;
      end else begin
         rx_s1_reg    <= i_monitor_rx;
         rx_s2_reg    <= rx_s1_reg;
         rx_s3_reg    <= rx_s2_reg;
         rx_f_reg     <= rx_f_next;
         rx_st_reg    <= rx_st_next;
         rx_ph_reg    <= rx_ph_next;
         rx_bit_reg   <= rx_bit_next;
         rx_sh_reg    <= rx_sh_next;
         rx_data_reg  <= rx_data_next;
         rx_valid_reg <= rx_valid_next;
         rx_err_reg   <= rx_err_next;
      end
   end

   assign o_rx_valid     = rx_valid_reg;
   assign o_rx_data      = rx_data_reg;
   assign o_rx_frame_err = rx_err_reg;

endmodule : ssm_top
